/* hw/gccs_pkg.sv */
// Constants and types shared by the common command and status unit
package gccs_pkg;

	// ==========================================================
	// Event status bit positions and reset values
	localparam int ESR_OPC = 0;
	localparam int ESR_RQC = 1;
	localparam int ESR_QYE = 2;
	localparam int ESR_DDE = 3;
	localparam int ESR_EXE = 4;
	localparam int ESR_CME = 5;
	localparam int ESR_URQ = 6;
	localparam int ESR_PON = 7;
	localparam logic [7:0] ESR_RESET = 8'h80;
	localparam logic [7:0] ESE_RESET = 8'h00;
	localparam logic [7:0] ESR_NEVER = 8'h42;

	// ==========================================================
	// Status byte bit positions
	localparam int STB_PSU = 0;
	localparam int STB_LOCK = 1;
	localparam int STB_FOVL = 2;
	localparam int STB_BOVL = 3;
	localparam int STB_MAV = 4;
	localparam int STB_ESB = 5;
	localparam int STB_RQS = 6;

	// ==========================================================
	// Characters on the bus
	localparam logic [7:0] CH_LF = 8'h0A;
	localparam logic [7:0] CH_SP = 8'h20;
	localparam logic [7:0] CH_STAR = 8'h2A;
	localparam logic [7:0] CH_SEMI = 8'h3B;
	localparam logic [7:0] CH_QM = 8'h3F;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_NINE = 8'h39;
	localparam logic [7:0] CH_LA = 8'h61;
	localparam logic [7:0] CH_LZ = 8'h7A;
	localparam logic [7:0] CH_UA = 8'h41;
	localparam logic [7:0] CH_UZ = 8'h5A;
	localparam logic [7:0] CASE_MASK = 8'hDF;

	// ==========================================================
	// Header mnemonics, upper case
	localparam logic [23:0] HDR_IDN = 24'h49444E;
	localparam logic [23:0] HDR_RST = 24'h525354;
	localparam logic [23:0] HDR_TST = 24'h545354;
	localparam logic [23:0] HDR_OPC = 24'h4F5043;
	localparam logic [23:0] HDR_WAI = 24'h574149;
	localparam logic [23:0] HDR_CLS = 24'h434C53;
	localparam logic [23:0] HDR_ESE = 24'h455345;
	localparam logic [23:0] HDR_ESR = 24'h455352;

	// ==========================================================
	// Identification string, value arbitrary: "ACME,RX1,0,0"
	localparam int ID_LEN = 12;
	localparam int ID_MAX = 71;
	localparam logic [8*ID_LEN-1:0] ID_TEXT = 96'h41434D452C5258312C302C30;

	// ==========================================================
	// Numeric limits and sizes
	localparam logic [9:0] ARG_MAX = 10'h0FF;
	localparam logic [9:0] ARG_SAT = 10'h3E7;
	localparam int QUEUE_DEPTH = 128;
	localparam int QUEUE_WIDTH = 9;

	typedef enum logic [3:0] {
		GCCS_CMD_BAD, GCCS_CMD_IDN, GCCS_CMD_RST, GCCS_CMD_TST, GCCS_CMD_OPC,
		GCCS_CMD_WAI, GCCS_CMD_CLS, GCCS_CMD_ESE, GCCS_CMD_ESR
	} gccs_cmd_t;

	typedef enum logic [3:0] {
		GCCS_IDLE, GCCS_HDR, GCCS_QRY, GCCS_ARGWS, GCCS_ARG, GCCS_TAIL, GCCS_SKIP,
		GCCS_EXEC, GCCS_SEP, GCCS_BODY, GCCS_TERM
	} gccs_state_t;

	typedef enum logic {GCCS_SRC_NUM, GCCS_SRC_STR} gccs_src_t;

endpackage : gccs_pkg

/* hw/gccs_q_if.sv */
// Response queue link between the command unit and its memory
`timescale 1ns/100ps
interface gccs_q_if #(parameter int WIDTH = 9);
	logic push;
	logic [WIDTH-1:0] push_data;
	logic pop;
	logic [WIDTH-1:0] pop_data;
	logic flush;
	logic full;
	logic empty;

	modport unit (output push, output push_data, output pop, output flush,
		input pop_data, input full, input empty);
	modport mem (input push, input push_data, input pop, input flush,
		output pop_data, output full, output empty);
endinterface : gccs_q_if

/* hw/gccs_resp_mem.sv */
// Response queue storage with registered read data
`timescale 1ns/100ps
module gccs_resp_mem #(
	parameter int DEPTH = gccs_pkg::QUEUE_DEPTH,
	parameter int WIDTH = gccs_pkg::QUEUE_WIDTH
) (
	input wire logic core_clk,
	input wire logic nrst,
	gccs_q_if.mem q
);
	localparam int AW = $clog2(DEPTH);

	// ==========================================================
	// Checks
	initial begin
		if (DEPTH <= gccs_pkg::ID_MAX || DEPTH != (1 << AW))
			$error("queue depth must be a power of two above the longest response");
	end

	logic [WIDTH-1:0] store [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;

	assign q.full = (count == (AW+1)'(DEPTH));
	assign q.empty = (count == '0);

	// Pointers and fill level; flush drops everything unread
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else if (q.flush) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (q.push && !q.full)
				wr_ptr <= wr_ptr + 1'b1;
			if (q.pop && !q.empty)
				rd_ptr <= rd_ptr + 1'b1;
			count <= count + (AW+1)'(q.push && !q.full) - (AW+1)'(q.pop && !q.empty);
		end
	end

	// Storage array, no reset so it maps to RAM
	always_ff @(posedge core_clk) begin
		if (q.push && !q.full)
			store[wr_ptr] <= q.push_data;
	end

	// Read data register, valid the cycle after pop
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst)
			q.pop_data <= '0;
		else if (q.pop && !q.empty)
			q.pop_data <= store[rd_ptr];
	end
endmodule : gccs_resp_mem

/* hw/gccs_hdr_match.sv */
// Maps a three letter upper case header onto a command code
`timescale 1ns/100ps
module gccs_hdr_match (
	input wire logic [23:0] hdr,
	output gccs_pkg::gccs_cmd_t cmd
);
	// Pure decode; unknown headers fall to the bad code
	always_comb begin
		case (hdr)
			gccs_pkg::HDR_IDN: cmd = gccs_pkg::GCCS_CMD_IDN;
			gccs_pkg::HDR_RST: cmd = gccs_pkg::GCCS_CMD_RST;
			gccs_pkg::HDR_TST: cmd = gccs_pkg::GCCS_CMD_TST;
			gccs_pkg::HDR_OPC: cmd = gccs_pkg::GCCS_CMD_OPC;
			gccs_pkg::HDR_WAI: cmd = gccs_pkg::GCCS_CMD_WAI;
			gccs_pkg::HDR_CLS: cmd = gccs_pkg::GCCS_CMD_CLS;
			gccs_pkg::HDR_ESE: cmd = gccs_pkg::GCCS_CMD_ESE;
			gccs_pkg::HDR_ESR: cmd = gccs_pkg::GCCS_CMD_ESR;
			default: cmd = gccs_pkg::GCCS_CMD_BAD;
		endcase
	end
endmodule : gccs_hdr_match

/* hw/gccs_unit.sv */
// Common command interpreter, event status register and status byte
`timescale 1ns/100ps

// What this block does
// (R1) Trigger from host starts nothing; only flags an error mid-message.
// (R2) Bus control only in master mode, never while remote.
// (R3) Incoming message ends on end-or-identify or linefeed; responses end with both.
// (R4) Serial poll returns full status byte, bit 6 shows service request.
// (R5) Commands are ASCII, letters matched regardless of case.
// (R6) Responses joined by semicolons; emptied message ends linefeed plus end-or-identify.
// (R7) Identify answers maker, model, serial, firmware separated by commas.
// (R8) Identify answer under 72 characters; unread output discarded by next query.
// (R9) Reset command restores power-up settings, remote mode kept.
// (R10) Self-test query always answers zero.
// (R11) Operation complete command sets event bit 0 right after handling.
// (R12) Operation complete query answers character 1 immediately.
// (R13) Wait command accepted silently.
// (R14) Clear status clears all status event bits.
// (R15) Event register bit layout; bits 1 and 6 never set.
// (R16) Masked event bits ORed into summary, status byte bit 5.
// (R17) Query error on reading with nothing available or on lost data.
// (R18) Device dependent error set from device failures.
// (R19) Execution error on out-of-range data or state preventing execution.
// (R20) Command error on syntax fault, unknown command, or mid-message trigger.
// (R21) Mask command needs whitespace then decimal 0 to 255; query returns it.
// (R22) Event status query returns unmasked register, then clears it.
// (R23) Status byte carries faults, message available, summary, service request.
// (R24) Bit 6 of service request mask ignored.
// (R25) Several commands in one message separated by semicolons.
// (R26) Event bits stay set until read or cleared.
module gccs_unit (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [7:0] rx_data,
	input wire logic rx_valid,
	input wire logic rx_eoi,
	output logic rx_ready,
	output logic [7:0] tx_data,
	output logic tx_eoi,
	output logic tx_valid,
	input wire logic tx_ready,
	input wire logic talk_req,
	input wire logic trigger,
	input wire logic remote,
	input wire logic master_mode,
	output logic bus_ctrl,
	input wire logic psu_fault,
	input wire logic lock_fault,
	input wire logic front_ovld,
	input wire logic back_ovld,
	input wire logic dev_error,
	input wire logic exec_fault,
	input wire logic [7:0] sre_mask,
	output logic [7:0] status_byte,
	output logic srq,
	output logic settings_restore
);
	gccs_q_if #(.WIDTH(gccs_pkg::QUEUE_WIDTH)) q ();
	gccs_pkg::gccs_state_t state;
	gccs_pkg::gccs_cmd_t cmd;
	gccs_pkg::gccs_src_t src;
	logic [23:0] hdr;
	logic [1:0] hcnt;
	logic qflag, has_arg, bad, term, resp_in_msg, fetch_pend;
	logic [9:0] arg_val;
	logic [7:0] esr, ese_mask, emit_val, set_v, clr_v, esr_snap, ch_up;
	logic [6:0] emit_idx;
	logic [7:0] body_ch;
	logic body_last, is_ws, is_digit, is_alpha, is_delim, ends_msg, take, q_ok, cmd_ok, out_busy;
	logic term_is_esr;

	gccs_resp_mem #(.DEPTH(gccs_pkg::QUEUE_DEPTH), .WIDTH(gccs_pkg::QUEUE_WIDTH)) u_mem (
		.core_clk(core_clk),
		.nrst(nrst),
		.q(q)
	);

	gccs_hdr_match u_match (
		.hdr(hdr),
		.cmd(cmd)
	);

	// ==========================================================
	// Character classes
	assign ch_up = (rx_data >= gccs_pkg::CH_LA && rx_data <= gccs_pkg::CH_LZ) ?
		(rx_data & gccs_pkg::CASE_MASK) : rx_data; // R5
	assign is_alpha = ch_up >= gccs_pkg::CH_UA && ch_up <= gccs_pkg::CH_UZ;
	assign is_digit = rx_data >= gccs_pkg::CH_ZERO && rx_data <= gccs_pkg::CH_NINE;
	assign is_ws = rx_data <= gccs_pkg::CH_SP && rx_data != gccs_pkg::CH_LF;
	assign is_delim = rx_data == gccs_pkg::CH_LF || rx_data == gccs_pkg::CH_SEMI; // R25
	assign ends_msg = rx_data == gccs_pkg::CH_LF || rx_eoi; // R3
	assign rx_ready = state <= gccs_pkg::GCCS_SKIP;
	assign take = rx_valid && rx_ready;
	assign out_busy = !q.empty || tx_valid || fetch_pend;

	// Which header/query/argument shapes are legal
	always_comb begin
		q_ok = 1'b0;
		cmd_ok = 1'b0;
		if (!bad) begin
			case (cmd)
				gccs_pkg::GCCS_CMD_IDN, gccs_pkg::GCCS_CMD_TST, gccs_pkg::GCCS_CMD_ESR:
					q_ok = qflag && !has_arg;
				gccs_pkg::GCCS_CMD_OPC: begin
					q_ok = qflag && !has_arg; // R12
					cmd_ok = !qflag && !has_arg;
				end
				gccs_pkg::GCCS_CMD_ESE: begin
					q_ok = qflag && !has_arg;
					cmd_ok = !qflag && has_arg; // R21
				end
				gccs_pkg::GCCS_CMD_RST, gccs_pkg::GCCS_CMD_WAI, gccs_pkg::GCCS_CMD_CLS:
					cmd_ok = !qflag && !has_arg; // R13
				default: begin
					q_ok = 1'b0;
					cmd_ok = 1'b0;
				end
			endcase
		end
	end

	// ==========================================================
	// Parser and sequencer; later assignments override earlier
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state <= gccs_pkg::GCCS_IDLE;
			hdr <= '0;
			hcnt <= '0;
			qflag <= 1'b0;
			has_arg <= 1'b0;
			arg_val <= '0;
			bad <= 1'b0;
			term <= 1'b0;
		end else begin
			case (state)
				gccs_pkg::GCCS_IDLE: begin
					if (take && rx_data == gccs_pkg::CH_STAR) begin
						state <= gccs_pkg::GCCS_HDR;
						hcnt <= '0;
						qflag <= 1'b0;
						has_arg <= 1'b0;
						arg_val <= '0;
						bad <= 1'b0;
					end else if (take && !is_ws && !is_delim) begin
						state <= gccs_pkg::GCCS_SKIP; // R20
						bad <= 1'b1;
					end
				end
				gccs_pkg::GCCS_HDR: if (take) begin
					hdr <= {hdr[15:0], ch_up};
					hcnt <= hcnt + 2'd1;
					if (!is_alpha) begin
						bad <= 1'b1;
						state <= gccs_pkg::GCCS_SKIP;
					end else if (hcnt == 2'd2)
						state <= gccs_pkg::GCCS_QRY;
				end
				gccs_pkg::GCCS_QRY: if (take) begin
					if (rx_data == gccs_pkg::CH_QM) begin
						qflag <= 1'b1;
						state <= gccs_pkg::GCCS_TAIL;
					end else if (is_ws)
						state <= gccs_pkg::GCCS_ARGWS; // R21
					else if (!is_delim) begin
						bad <= 1'b1;
						state <= gccs_pkg::GCCS_SKIP;
					end
				end
				gccs_pkg::GCCS_ARGWS: if (take && !is_ws) begin
					if (is_digit) begin
						has_arg <= 1'b1;
						arg_val <= 10'(rx_data - gccs_pkg::CH_ZERO);
						state <= gccs_pkg::GCCS_ARG;
					end else begin
						bad <= 1'b1;
						state <= gccs_pkg::GCCS_SKIP;
					end
				end
				gccs_pkg::GCCS_ARG: if (take) begin
					if (is_digit)
						arg_val <= (arg_val > 10'd99) ? gccs_pkg::ARG_SAT :
							10'(arg_val * 10'd10 + 10'(rx_data - gccs_pkg::CH_ZERO));
					else if (is_ws)
						state <= gccs_pkg::GCCS_TAIL;
					else if (!is_delim) begin
						bad <= 1'b1;
						state <= gccs_pkg::GCCS_SKIP;
					end
				end
				gccs_pkg::GCCS_TAIL: if (take && !is_ws && !is_delim) begin
					bad <= 1'b1;
					state <= gccs_pkg::GCCS_SKIP;
				end
				gccs_pkg::GCCS_SKIP: ;
				gccs_pkg::GCCS_EXEC: begin
					if (q_ok)
						state <= resp_in_msg ? gccs_pkg::GCCS_SEP : gccs_pkg::GCCS_BODY;
					else if (term && resp_in_msg)
						state <= gccs_pkg::GCCS_TERM;
					else
						state <= gccs_pkg::GCCS_IDLE;
				end
				gccs_pkg::GCCS_SEP: if (!q.full)
					state <= gccs_pkg::GCCS_BODY;
				gccs_pkg::GCCS_BODY: if (!q.full && body_last)
					state <= term ? gccs_pkg::GCCS_TERM : gccs_pkg::GCCS_IDLE;
				gccs_pkg::GCCS_TERM: if (!q.full)
					state <= gccs_pkg::GCCS_IDLE;
				default: state <= gccs_pkg::GCCS_IDLE;
			endcase
			// Delimiter or end-or-identify closes the command in hand
			if (take && (is_delim || rx_eoi)) begin
				term <= ends_msg; // R3
				if (state == gccs_pkg::GCCS_HDR && !(is_alpha && hcnt == 2'd2 && !is_delim))
					bad <= 1'b1;
				if (state == gccs_pkg::GCCS_IDLE && rx_data == gccs_pkg::CH_STAR)
					bad <= 1'b1;
				if (state != gccs_pkg::GCCS_IDLE || rx_data == gccs_pkg::CH_STAR
						|| !(is_ws || is_delim))
					state <= gccs_pkg::GCCS_EXEC;
				else if (ends_msg && resp_in_msg)
					state <= gccs_pkg::GCCS_TERM;
			end
		end
	end

	// ==========================================================
	// Response emission: one character per cycle, stalls on a full queue
	always_comb begin
		body_ch = gccs_pkg::CH_ZERO;
		body_last = 1'b0;
		if (src == gccs_pkg::GCCS_SRC_STR) begin
			body_ch = gccs_pkg::ID_TEXT[8*(gccs_pkg::ID_LEN-1-int'(emit_idx)) +: 8]; // R7
			body_last = emit_idx == 7'(gccs_pkg::ID_LEN - 1);
		end else begin
			case (emit_idx)
				7'd0: body_ch = gccs_pkg::CH_ZERO + emit_val / 8'd100;
				7'd1: body_ch = gccs_pkg::CH_ZERO + (emit_val / 8'd10) % 8'd10;
				default: body_ch = gccs_pkg::CH_ZERO + emit_val % 8'd10;
			endcase
			body_last = emit_idx >= 7'd2;
		end
	end

	assign q.push = !q.full && (state == gccs_pkg::GCCS_SEP || state == gccs_pkg::GCCS_BODY
		|| state == gccs_pkg::GCCS_TERM);
	assign q.push_data = (state == gccs_pkg::GCCS_TERM) ? {1'b1, gccs_pkg::CH_LF} : // R6
		(state == gccs_pkg::GCCS_SEP) ? {1'b0, gccs_pkg::CH_SEMI} : {1'b0, body_ch};
	// A new query while the last message is still unread throws that output away
	assign q.flush = state == gccs_pkg::GCCS_EXEC && q_ok && !resp_in_msg && out_busy; // R8

	// Source and index of the answer being emitted
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			src <= gccs_pkg::GCCS_SRC_NUM;
			emit_idx <= '0;
			emit_val <= '0;
			resp_in_msg <= 1'b0;
		end else if (state == gccs_pkg::GCCS_EXEC && q_ok) begin
			src <= (cmd == gccs_pkg::GCCS_CMD_IDN) ? gccs_pkg::GCCS_SRC_STR : gccs_pkg::GCCS_SRC_NUM;
			case (cmd)
				gccs_pkg::GCCS_CMD_TST: emit_val <= 8'h00; // R10
				gccs_pkg::GCCS_CMD_OPC: emit_val <= 8'h01; // R12
				gccs_pkg::GCCS_CMD_ESE: emit_val <= ese_mask; // R21
				gccs_pkg::GCCS_CMD_ESR: emit_val <= esr; // R22
				default: emit_val <= 8'h00;
			endcase
			// Leading zeros are skipped by starting part way in
			if (cmd == gccs_pkg::GCCS_CMD_IDN)
				emit_idx <= '0;
			else if (cmd == gccs_pkg::GCCS_CMD_ESE)
				emit_idx <= (ese_mask >= 8'd100) ? 7'd0 : (ese_mask >= 8'd10) ? 7'd1 : 7'd2;
			else if (cmd == gccs_pkg::GCCS_CMD_ESR)
				emit_idx <= (esr >= 8'd100) ? 7'd0 : (esr >= 8'd10) ? 7'd1 : 7'd2;
			else
				emit_idx <= 7'd2;
		end else if (state == gccs_pkg::GCCS_BODY && !q.full) begin
			emit_idx <= emit_idx + 7'd1;
			if (body_last)
				resp_in_msg <= 1'b1; // R6
		end else if (state == gccs_pkg::GCCS_TERM && !q.full)
			resp_in_msg <= 1'b0;
	end

	// ==========================================================
	// Talker side: pop, then hold the byte until the host takes it
	assign q.pop = !tx_valid && !fetch_pend && !q.empty && !q.flush;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			fetch_pend <= 1'b0;
			tx_valid <= 1'b0;
			tx_data <= '0;
			tx_eoi <= 1'b0;
		end else if (q.flush) begin
			fetch_pend <= 1'b0;
			tx_valid <= 1'b0;
		end else if (fetch_pend) begin
			fetch_pend <= 1'b0;
			tx_valid <= 1'b1;
			tx_data <= q.pop_data[7:0];
			tx_eoi <= q.pop_data[8]; // R3
		end else if (tx_valid && tx_ready)
			tx_valid <= 1'b0;
		else if (q.pop)
			fetch_pend <= 1'b1;
	end

	// ==========================================================
	// Event status register: sticky, set wins over any clear
	always_comb begin
		set_v = '0;
		clr_v = '0;
		if (state == gccs_pkg::GCCS_EXEC) begin
			set_v[gccs_pkg::ESR_OPC] = cmd == gccs_pkg::GCCS_CMD_OPC && cmd_ok; // R11
			set_v[gccs_pkg::ESR_CME] = !q_ok && !cmd_ok; // R20
			set_v[gccs_pkg::ESR_EXE] = cmd == gccs_pkg::GCCS_CMD_ESE && cmd_ok
				&& arg_val > gccs_pkg::ARG_MAX; // R19
			set_v[gccs_pkg::ESR_QYE] = q.flush; // R17
			if (cmd == gccs_pkg::GCCS_CMD_CLS && cmd_ok)
				clr_v = 8'hFF; // R14
		end
		if (state == gccs_pkg::GCCS_BODY && !q.full && body_last && src == gccs_pkg::GCCS_SRC_NUM
				&& term_is_esr)
			clr_v = esr_snap; // R22
		set_v[gccs_pkg::ESR_CME] = set_v[gccs_pkg::ESR_CME]
			| (trigger && state != gccs_pkg::GCCS_IDLE); // R1 R20
		set_v[gccs_pkg::ESR_QYE] = set_v[gccs_pkg::ESR_QYE] | (talk_req && !out_busy
			&& state < gccs_pkg::GCCS_EXEC); // R17
		set_v[gccs_pkg::ESR_DDE] = dev_error; // R18
		set_v[gccs_pkg::ESR_EXE] = set_v[gccs_pkg::ESR_EXE] | exec_fault; // R19
		set_v = set_v & ~gccs_pkg::ESR_NEVER; // R15
	end

	// Which query is being emitted, and the value it reported
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			term_is_esr <= 1'b0;
			esr_snap <= '0;
		end else if (state == gccs_pkg::GCCS_EXEC && q_ok) begin
			term_is_esr <= cmd == gccs_pkg::GCCS_CMD_ESR;
			esr_snap <= esr;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst)
			esr <= gccs_pkg::ESR_RESET; // R15
		else
			esr <= (esr & ~clr_v) | set_v; // R26
	end

	// Mask register; kept across the reset command like other interface state
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst)
			ese_mask <= gccs_pkg::ESE_RESET;
		else if (state == gccs_pkg::GCCS_EXEC && cmd == gccs_pkg::GCCS_CMD_ESE && cmd_ok
				&& arg_val <= gccs_pkg::ARG_MAX)
			ese_mask <= arg_val[7:0]; // R21
	end

	// ==========================================================
	// Status byte, service request, reset pulse, bus control
	logic [7:0] stb_raw;
	assign stb_raw = {1'b0, 1'b0, |(esr & ese_mask), out_busy, back_ovld, front_ovld,
		lock_fault, psu_fault}; // R23 R16
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			srq <= 1'b0;
			status_byte <= '0;
			settings_restore <= 1'b0;
			bus_ctrl <= 1'b0;
		end else begin
			srq <= |(stb_raw & sre_mask & 8'hBF); // R24
			status_byte <= stb_raw | {1'b0, |(stb_raw & sre_mask & 8'hBF), 6'h00}; // R4
			settings_restore <= state == gccs_pkg::GCCS_EXEC && cmd == gccs_pkg::GCCS_CMD_RST
				&& cmd_ok; // R9
			bus_ctrl <= master_mode && !remote; // R2
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	a_esr_never_set: assert property (!esr[gccs_pkg::ESR_RQC] && !esr[gccs_pkg::ESR_URQ]) // R15
		else $error("unused event bits set");
	a_esb_summary: assert property (status_byte[gccs_pkg::STB_ESB] == $past(|(esr & ese_mask))) // R16
		else $error("summary bit wrong");
	a_srq_bit_six: assert property (status_byte[gccs_pkg::STB_RQS] == srq) // R4
		else $error("status bit 6 disagrees with service request");
	a_ctrl_not_remote: assert property (remote |=> !bus_ctrl) // R2
		else $error("bus control while remote");
	a_trig_idle_quiet: assert property (trigger && state == gccs_pkg::GCCS_IDLE && !rx_valid
		|=> !settings_restore && $stable(ese_mask)) // R1
		else $error("trigger started activity");
	a_term_lf_eoi: assert property (q.push && q.push_data[8] |-> q.push_data[7:0] == gccs_pkg::CH_LF) // R6
		else $error("end marker without linefeed");
	a_opc_sets_bit: assert property (state == gccs_pkg::GCCS_EXEC && cmd == gccs_pkg::GCCS_CMD_OPC
		&& cmd_ok |=> esr[gccs_pkg::ESR_OPC]) // R11
		else $error("operation complete not set");
	a_cls_clears: assert property (state == gccs_pkg::GCCS_EXEC && cmd == gccs_pkg::GCCS_CMD_CLS
		&& cmd_ok && !dev_error && !exec_fault && !trigger && !talk_req |=> esr == 8'h00) // R14
		else $error("clear status left bits");
	a_empty_read_qye: assert property (talk_req && !out_busy && state == gccs_pkg::GCCS_IDLE
		|=> esr[gccs_pkg::ESR_QYE]) // R17
		else $error("query error missing");
	a_rst_pulse: assert property (settings_restore |-> $past(state) == gccs_pkg::GCCS_EXEC) // R9
		else $error("restore without command");
	a_bad_sets_cme: assert property (state == gccs_pkg::GCCS_EXEC && bad |=> esr[gccs_pkg::ESR_CME]) // R20
		else $error("command error missing");

	c_idn_answer: cover property (state == gccs_pkg::GCCS_BODY && src == gccs_pkg::GCCS_SRC_STR && body_last);
	c_esr_read: cover property (state == gccs_pkg::GCCS_EXEC && cmd == gccs_pkg::GCCS_CMD_ESR && q_ok);
	c_flush: cover property (q.flush);
	c_tx_end: cover property (tx_valid && tx_ready && tx_eoi);
endmodule : gccs_unit

/* bench/gccs_host_model.sv */
// Host controller model reading response bytes off the talker port
`timescale 1ns/100ps
module gccs_host_model (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	input wire logic tx_eoi,
	output logic tx_ready,
	input wire logic slow,
	input wire logic clr,
	output logic [127:0] resp,
	output logic done
);
	// ======
	// Reader
	// Every offered byte is read, so no answer is left to be discarded
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			tx_ready <= 1'b0;
			resp <= '0;
			done <= 1'b0;
		end else begin
			tx_ready <= slow ? ~tx_ready : 1'b1;
			if (clr) begin
				resp <= '0;
				done <= 1'b0;
			end else if (tx_valid && tx_ready) begin
				resp <= {resp[119:0], tx_data};
				done <= tx_eoi; // Message ends on the byte with end-or-identify
			end
		end
	end
endmodule : gccs_host_model

/* bench/gccs_unit_tb_top.sv */
// Self-checking bench for the common command and status unit
`timescale 1ns/100ps
module gccs_unit_tb_top;
	logic core_clk = 1'b0, nrst = 1'b0, rx_valid = 1'b0, rx_eoi = 1'b0, talk_req = 1'b0;
	logic remote = 1'b0, master_mode = 1'b0, trigger = 1'b0, dev_error = 1'b0;
	logic [3:0] faults = 4'h0;
	logic slow = 1'b0, clr = 1'b0;
	logic [7:0] rx_data = 8'h00, sre_mask = 8'h00;
	logic rx_ready, tx_eoi, tx_valid, tx_ready, bus_ctrl, srq, settings_restore, done;
	logic [7:0] tx_data, status_byte;
	logic [127:0] resp;
	int fail_count = 0, cmp_count = 0;

	// ======
	// Harness
	always #50 core_clk = ~core_clk;
	gccs_unit u_dut (.core_clk(core_clk), .nrst(nrst), .rx_data(rx_data), .rx_valid(rx_valid),
		.rx_eoi(rx_eoi), .rx_ready(rx_ready), .tx_data(tx_data), .tx_eoi(tx_eoi), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .talk_req(talk_req), .trigger(trigger), .remote(remote),
		.master_mode(master_mode), .bus_ctrl(bus_ctrl), .psu_fault(faults[0]), .lock_fault(faults[1]),
		.front_ovld(faults[2]), .back_ovld(faults[3]), .dev_error(dev_error), .exec_fault(dev_error),
		.sre_mask(sre_mask), .status_byte(status_byte), .srq(srq), .settings_restore(settings_restore));
	gccs_host_model u_host (.core_clk(core_clk), .nrst(nrst), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_eoi(tx_eoi), .tx_ready(tx_ready), .slow(slow), .clr(clr), .resp(resp), .done(done));

	task automatic results();
		$display("compared %0d, wrong %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : results

	task automatic check(input string name, input logic [127:0] seen, input logic [127:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s: expected %h, seen %h", name, exp, seen);
		end
	endtask : check

	// Bounded wait at falling edges, where registered outputs have settled
	task automatic await(input string name, ref logic sig);
		int n;
		n = 0;
		@(negedge core_clk);
		while (sig !== 1'b1) begin
			if (++n > 400) begin
				fail_count++;
				$display("wrong value %s: expected 1, seen timeout", name);
				results();
			end
			@(negedge core_clk);
		end
	endtask : await

	// Bytes are held until taken; entered and left at a rising edge
	task automatic send(input string s, input logic eoi);
		clr <= 1'b1;
		for (int i = 0; i < s.len(); i++) begin
			rx_data <= s[i];
			rx_valid <= 1'b1;
			rx_eoi <= eoi && (i == s.len() - 1);
			await("rx_ready", rx_ready);
			@(posedge core_clk);
			clr <= 1'b0;
		end
		rx_valid <= 1'b0;
		rx_eoi <= 1'b0;
	endtask : send

	task automatic ask(input string s, input logic eoi, input logic [127:0] exp);
		send(s, eoi);
		await("response", done);
		check(s, resp, exp);
		@(posedge core_clk);
	endtask : ask

	// ======
	// Scenarios
	task automatic t_reset();
		check("status_byte", status_byte, 8'h00);
		ask("*ESR?\n", 1'b0, "128\n");
		ask("*esr?", 1'b1, "0\n");
		$display("test reset done");
	endtask : t_reset

	// Host is ready only every other cycle while several answers are joined
	task automatic t_multi();
		slow <= 1'b1;
		ask("*ESE 36;*ESE?;*TST?;*OPC?;*WAI\n", 1'b0, "36;0;1\n");
		slow <= 1'b0;
		ask("*IDN?\n", 1'b0, "ACME,RX1,0,0\n");
		$display("test multi done");
	endtask : t_multi

	task automatic t_events();
		ask("*OPC;*ESR?\n", 1'b0, "1\n");
		dev_error <= 1'b1;
		talk_req <= 1'b1;
		@(posedge core_clk);
		dev_error <= 1'b0;
		talk_req <= 1'b0;
		send("*ESE 300;*XYZ\n", 1'b0);
		repeat (4) @(negedge core_clk);
		check("esb", status_byte[5], 1'b1);
		@(posedge core_clk);
		ask("*ESR?\n", 1'b0, "60\n");
		ask("*OPC;*CLS;*ESR?\n", 1'b0, "0\n");
		send("*RST\n", 1'b0);
		await("settings_restore", settings_restore);
		@(posedge core_clk);
		$display("test events done");
	endtask : t_events

	// Trigger is ignored when idle, a command error in mid-message
	task automatic t_trig();
		trigger <= 1'b1;
		@(posedge core_clk);
		trigger <= 1'b0;
		ask("*ESR?\n", 1'b0, "0\n");
		send("*ESE", 1'b0);
		trigger <= 1'b1;
		@(posedge core_clk);
		trigger <= 1'b0;
		send(" 4\n", 1'b0);
		@(posedge core_clk);
		ask("*ESR?\n", 1'b0, "32\n");
		ask("*ESE?\n", 1'b0, "4\n");
		$display("test trigger done");
	endtask : t_trig

	task automatic t_status();
		faults <= 4'hF;
		sre_mask <= 8'h41;
		master_mode <= 1'b1;
		repeat (3) @(negedge core_clk);
		check("status_byte", status_byte, 8'h4F);
		check("srq", srq, 1'b1);
		check("bus_ctrl", bus_ctrl, 1'b1);
		@(posedge core_clk);
		remote <= 1'b1;
		repeat (3) @(negedge core_clk);
		check("bus_ctrl", bus_ctrl, 1'b0);
		$display("test status done");
	endtask : t_status

	initial begin
		repeat (12) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		t_reset();
		t_multi();
		t_events();
		t_trig();
		t_status();
		results();
	end
endmodule : gccs_unit_tb_top
